// ===== logic/dpsub_map.svh
/*
  Constants for the dot-product subtract unit: instruction field codes,
  APB register offsets, field positions and reset values.
  Assumes inclusion by the unit only, by its bare name.
*/
`ifndef DPSUB_MAP_SVH
`define DPSUB_MAP_SVH

`define MAJOR_GROUP_CODE 6'h00
`define MINOR_GROUP_CODE 6'h3c
`define FN_CROSS_PROD_SAT 8'h9a
`define FN_CROSS_SUM_SAT 8'hca
`define FN_LEFT_BYTE_SUB 8'h92

`define OFS_CTRL 8'h00
`define OFS_FLAGS 8'h04
`define OFS_IRQ_STATUS 8'h08
`define OFS_IRQ_MASK 8'h0c
`define OFS_ACC_BASE 8'h10
`define OFS_ACC_LAST 8'h2c

`define CTRL_ENABLE_BIT 0
`define CTRL_RESET 32'h0000_0001
`define OUFLAG_LSB 16
`define IRQ_SAT_BIT 0
`define IRQ_EXC_BIT 1
`define Q15_MINUS_ONE 16'h8000
`define Q31_MAX 32'h7fffffff
`define SUM_SAT_POS 64'h0000_0000_7fff_ffff
`define SUM_SAT_NEG 64'hffff_ffff_8000_0000

`endif

// ===== logic/dpsub_pkg.sv
/*
  Types shared by the dot-product subtract unit.
  Assumes nothing beyond the map header.
*/
package dpsub_pkg;
  typedef enum logic [1:0] {
    OP_NONE,
    OP_CROSS_PROD_SAT,
    OP_CROSS_SUM_SAT,
    OP_LEFT_BYTE_SUB
  } op_t;
endpackage

// ===== logic/dot_product_subtract_unit.sv
/*
  Dot-product subtract unit: three cross/byte dot-product subtract
  operations on four 64-bit accumulators, overflow flags, APB register
  access and a level interrupt.
  Register map: control (bit 0 enables the ops, set after reset),
  overflow flags in bits 19..16, interrupt status (bit 0 saturation,
  bit 1 refused instruction, write one to clear), interrupt mask of the
  same layout, then each accumulator as bottom word and upper word.
  Unmapped or unaligned addresses answer with PSLVERR and no effect.
  Flags and status: a hardware set beats a same-cycle software write.
  Assumes instruction word and operands arrive from the core on SYS_CLK,
  one operation per valid cycle, with operands already read.
  Assumes the core raises its own trap from EXC_RESERVED and
  EXC_SP_DISABLED one cycle after issue; this unit never traps on data.
  Assumes the APB master holds each request until PREADY, which comes
  after one wait state; PRDATA and PSLVERR stand only with PREADY.
  Accumulator results are visible to the very next instruction, so the
  core may issue back to back without a forwarding path of its own.
  Limitation: an APB write to an accumulator in the cycle an op writes
  it is lost; software should quiesce the core first.
*/
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "dpsub_map.svh"

module dot_product_subtract_unit #(
  parameter int ADDR_W = 8,
  parameter int ACC_COUNT = 4
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic INSTR_VALID,
  input wire logic [31:0] INSTR_WORD,
  input wire logic [31:0] LEFT_OPERAND_GPR,
  input wire logic [31:0] RIGHT_OPERAND_GPR,
  output logic OP_DONE,
  output logic EXC_RESERVED,
  output logic EXC_SP_DISABLED,
  output logic [3:0] OVERFLOW_FLAGS,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic IRQ
);

  function automatic dpsub_pkg::op_t decode_op(input logic [31:0] w);
    dpsub_pkg::op_t op;
    op = dpsub_pkg::OP_NONE;
    if (w[31:26] == `MAJOR_GROUP_CODE && w[5:0] == `MINOR_GROUP_CODE) begin
      if (w[13:6] == `FN_CROSS_PROD_SAT) begin
        op = dpsub_pkg::OP_CROSS_PROD_SAT;
      end else if (w[13:6] == `FN_CROSS_SUM_SAT) begin
        op = dpsub_pkg::OP_CROSS_SUM_SAT;
      end else if (w[13:6] == `FN_LEFT_BYTE_SUB) begin
        op = dpsub_pkg::OP_LEFT_BYTE_SUB;
      end
    end
    return op;
  endfunction

  function automatic logic in_group(input logic [31:0] w);
    return w[31:26] == `MAJOR_GROUP_CODE && w[5:0] == `MINOR_GROUP_CODE;
  endfunction

  // Bit 32 flags saturation; bits 31..0 hold the Q31 product
  function automatic logic [32:0] mul_q15(input logic [15:0] a,
                                          input logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    if (a == `Q15_MINUS_ONE && b == `Q15_MINUS_ONE) begin
      return {1'b1, `Q31_MAX};
    end
    return {1'b0, p[30:0], 1'b0};
  endfunction

  // Bit 64 flags a clamp; bits 63..0 hold the Q31-bounded sum
  function automatic logic [64:0] clamp_q31(input logic [63:0] d);
    logic [64:0] r;
    r = {1'b0, d};
    if (!d[63] && d[62:31] != 32'h0000_0000) begin
      r = {1'b1, `SUM_SAT_POS};
    end else if (d[63] && d[62:31] != 32'hffff_ffff) begin
      r = {1'b1, `SUM_SAT_NEG};
    end
    return r;
  endfunction

  logic [31:0] upper_q [ACC_COUNT];
  logic [31:0] bottom_q [ACC_COUNT];
  logic [31:0] ctrl_q;
  logic [3:0] flags_q;
  logic [3:0] flags_d;
  logic [1:0] irq_status_q;
  logic [1:0] irq_status_d;
  logic [1:0] irq_mask_q;
  logic op_done_q;
  logic exc_reserved_q;
  logic exc_disabled_q;
  logic irq_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // Execution datapath
  dpsub_pkg::op_t op;
  logic [1:0] sel;
  logic [63:0] acc_cur;
  logic [32:0] prod_b;
  logic [32:0] prod_a;
  logic [63:0] dotp;
  logic [63:0] diff;
  logic [63:0] result;
  logic sat_event;
  logic exec_write;
  logic exc_reserved_d;
  logic exc_disabled_d;
  logic [15:0] byte_b;
  logic [15:0] byte_a;
  logic [3:0] flag_set;
  logic prod_sat;
  logic [63:0] byte_sum;
  logic [64:0] clamped;

  always_comb begin
    op = INSTR_VALID ? decode_op(INSTR_WORD) : dpsub_pkg::OP_NONE;
    sel = INSTR_WORD[15:14];
    acc_cur = {upper_q[sel], bottom_q[sel]};
  end

  // Both multiplier pairs run every cycle; the op picks what it needs
  always_comb begin
    prod_b = mul_q15(LEFT_OPERAND_GPR[31:16], RIGHT_OPERAND_GPR[15:0]);
    prod_a = mul_q15(LEFT_OPERAND_GPR[15:0], RIGHT_OPERAND_GPR[31:16]);
    prod_sat = prod_b[32] | prod_a[32];
    dotp = {{32{prod_b[31]}}, prod_b[31:0]}
         + {{32{prod_a[31]}}, prod_a[31:0]};
  end

  // Byte sum fits in 17 bits, so it never saturates
  always_comb begin
    byte_b = LEFT_OPERAND_GPR[31:24] * RIGHT_OPERAND_GPR[31:24];
    byte_a = LEFT_OPERAND_GPR[23:16] * RIGHT_OPERAND_GPR[23:16];
    byte_sum = {48'h0, byte_b} + {48'h0, byte_a};
  end

  always_comb begin
    diff = acc_cur - dotp;
    clamped = clamp_q31(diff);
  end

  always_comb begin
    result = acc_cur;
    sat_event = 1'b0;
    case (op)
      dpsub_pkg::OP_CROSS_PROD_SAT: begin
        result = diff;
        sat_event = prod_sat;
      end
      dpsub_pkg::OP_CROSS_SUM_SAT: begin
        result = clamped[63:0];
        sat_event = prod_sat | clamped[64];
      end
      dpsub_pkg::OP_LEFT_BYTE_SUB: begin
        result = acc_cur - byte_sum;
        sat_event = 1'b0;
      end
      default: begin
        result = acc_cur;
        sat_event = 1'b0;
      end
    endcase
  end

  // Values never trap; only decode and enable can refuse
  always_comb begin
    exc_disabled_d = op != dpsub_pkg::OP_NONE
                   && !ctrl_q[`CTRL_ENABLE_BIT];
    exc_reserved_d = INSTR_VALID && in_group(INSTR_WORD)
                   && op == dpsub_pkg::OP_NONE;
    exec_write = op != dpsub_pkg::OP_NONE && !exc_disabled_d;
  end

  // One flag bit only, however many saturations in one op
  for (genvar j = 0; j < ACC_COUNT; j++) begin : g_flag
    assign flag_set[j] = exec_write && sat_event && sel == 2'(j);
  end

  // APB decode
  logic apb_setup_access;
  logic apb_commit;
  logic apb_wr;
  logic [31:0] rd_data;
  logic addr_ok;
  logic [ADDR_W-1:0] acc_ofs;
  logic [1:0] acc_idx;
  logic wr_ctrl;
  logic wr_flags;
  logic wr_status;
  logic wr_mask;

  assign apb_setup_access = PSEL && PENABLE && !pready_q;
  assign apb_commit = PSEL && PENABLE && pready_q;
  assign apb_wr = apb_commit && PWRITE && !pslverr_q;

  always_comb begin
    wr_ctrl = apb_wr && PADDR == ADDR_W'(`OFS_CTRL);
    wr_flags = apb_wr && PADDR == ADDR_W'(`OFS_FLAGS);
    wr_status = apb_wr && PADDR == ADDR_W'(`OFS_IRQ_STATUS);
    wr_mask = apb_wr && PADDR == ADDR_W'(`OFS_IRQ_MASK);
  end

  always_comb begin
    rd_data = 32'h0000_0000;
    addr_ok = 1'b1;
    acc_ofs = PADDR - ADDR_W'(`OFS_ACC_BASE);
    acc_idx = acc_ofs[4:3];
    if (PADDR == ADDR_W'(`OFS_CTRL)) begin
      rd_data = ctrl_q;
    end else if (PADDR == ADDR_W'(`OFS_FLAGS)) begin
      rd_data = 32'(flags_q) << `OUFLAG_LSB;
    end else if (PADDR == ADDR_W'(`OFS_IRQ_STATUS)) begin
      rd_data = {30'h0, irq_status_q};
    end else if (PADDR == ADDR_W'(`OFS_IRQ_MASK)) begin
      rd_data = {30'h0, irq_mask_q};
    end else if (PADDR >= ADDR_W'(`OFS_ACC_BASE)
                 && PADDR <= ADDR_W'(`OFS_ACC_LAST)
                 && PADDR[1:0] == 2'b00) begin
      rd_data = acc_ofs[2] ? upper_q[acc_idx] : bottom_q[acc_idx];
    end else begin
      addr_ok = 1'b0;
    end
  end

  // One wait state: answer registered so outputs come from flops
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (apb_setup_access) begin
      pready_q <= 1'b1;
      pslverr_q <= !addr_ok;
      prdata_q <= PWRITE ? 32'h0000_0000 : rd_data;
    end else begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ctrl_q <= `CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl_q <= {31'h0, PWDATA[`CTRL_ENABLE_BIT]};
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      irq_mask_q <= 2'b00;
    end else if (wr_mask) begin
      irq_mask_q <= PWDATA[1:0];
    end
  end

  // Hardware set wins over a software write in the same cycle
  always_comb begin
    flags_d = flags_q;
    if (wr_flags) begin
      flags_d = PWDATA[`OUFLAG_LSB +: 4];
    end
    flags_d = flags_d | flag_set;
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      flags_q <= 4'h0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Accumulators: an executing operation beats a colliding APB write
  for (genvar i = 0; i < ACC_COUNT; i++) begin : g_acc
    logic hit_upper;
    logic hit_bottom;
    assign hit_upper = apb_wr
      && PADDR == ADDR_W'(`OFS_ACC_BASE + 8 * i + 4);
    assign hit_bottom = apb_wr
      && PADDR == ADDR_W'(`OFS_ACC_BASE + 8 * i);
    always_ff @(posedge SYS_CLK) begin
      if (SYS_RST) begin
        upper_q[i] <= 32'h0000_0000;
        bottom_q[i] <= 32'h0000_0000;
      end else if (exec_write && sel == 2'(i)) begin
        upper_q[i] <= result[63:32];
        bottom_q[i] <= result[31:0];
      end else begin
        if (hit_upper) begin
          upper_q[i] <= PWDATA;
        end
        if (hit_bottom) begin
          bottom_q[i] <= PWDATA;
        end
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      op_done_q <= 1'b0;
    end else begin
      op_done_q <= exec_write;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      exc_reserved_q <= 1'b0;
      exc_disabled_q <= 1'b0;
    end else begin
      exc_reserved_q <= exc_reserved_d;
      exc_disabled_q <= exc_disabled_d;
    end
  end

  // Interrupt status: events set, write-one clears, set wins
  always_comb begin
    irq_status_d = irq_status_q;
    if (wr_status) begin
      irq_status_d = irq_status_q & ~PWDATA[1:0];
    end
    if (flag_set != 4'h0) begin
      irq_status_d[`IRQ_SAT_BIT] = 1'b1;
    end
    if (exc_reserved_d || exc_disabled_d) begin
      irq_status_d[`IRQ_EXC_BIT] = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      irq_status_q <= 2'b00;
    end else begin
      irq_status_q <= irq_status_d;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irq_status_d & irq_mask_q);
    end
  end

  assign OP_DONE = op_done_q;
  assign EXC_RESERVED = exc_reserved_q;
  assign EXC_SP_DISABLED = exc_disabled_q;
  assign OVERFLOW_FLAGS = flags_q;
  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign IRQ = irq_q;

endmodule

// ===== sim/dpsub_assertions.sv
/* Port checker for the dot-product subtract unit.
   Assumes it is bound to the unit's top module, one clock domain. */
`timescale 1ns/100ps
module dpsub_assertions #(
  parameter int ADDR_W = 8
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic INSTR_VALID,
  input wire logic [31:0] INSTR_WORD,
  input wire logic [31:0] LEFT_OPERAND_GPR,
  input wire logic [31:0] RIGHT_OPERAND_GPR,
  input wire logic OP_DONE,
  input wire logic EXC_RESERVED,
  input wire logic EXC_SP_DISABLED,
  input wire logic [3:0] OVERFLOW_FLAGS,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic IRQ
);
  logic grp, known, byte_op, sat_in, wr;
  assign grp = INSTR_VALID && INSTR_WORD[31:26] == 6'h00
    && INSTR_WORD[5:0] == 6'h3c;
  assign known = grp && INSTR_WORD[13:6] inside {8'h9a, 8'hca, 8'h92};
  assign byte_op = known && INSTR_WORD[13:6] == 8'h92;
  assign sat_in = known && !byte_op && LEFT_OPERAND_GPR[31:16] == 16'h8000
    && RIGHT_OPERAND_GPR[15:0] == 16'h8000;
  // Software may rewrite flags, so APB writes mask the sticky, byte and one-bit flag checks
  assign wr = PSEL && PWRITE;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  chk_op_ack: assert property (
    known |=> OP_DONE ^ EXC_SP_DISABLED)
    else $error("known op got no single answer");
  chk_res_fn: assert property (
    grp && !known |=> EXC_RESERVED && !OP_DONE)
    else $error("unknown function not refused");
  chk_idle_quiet: assert property (
    !INSTR_VALID |=> !(OP_DONE || EXC_RESERVED || EXC_SP_DISABLED))
    else $error("answer without an instruction");
  chk_prod_flag: assert property (
    sat_in |=> OVERFLOW_FLAGS[$past(INSTR_WORD[15:14])] || EXC_SP_DISABLED)
    else $error("product saturation left flag clear");
  chk_flag_sticky: assert property (
    !wr |=> (OVERFLOW_FLAGS & $past(OVERFLOW_FLAGS)) == $past(OVERFLOW_FLAGS))
    else $error("overflow flag cleared by an op");
  chk_byte_keep: assert property (
    byte_op && !wr |=> $stable(OVERFLOW_FLAGS))
    else $error("byte op changed flags");
  chk_one_bit: assert property (
    !wr |=> (OVERFLOW_FLAGS & ~$past(OVERFLOW_FLAGS) & ~({3'h0,
    $past(INSTR_VALID)} << $past(INSTR_WORD[15:14]))) == 4'h0)
    else $error("flag set outside selected accumulator");
  chk_wait_state: assert property (
    PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("APB answer late");
  chk_ready_pulse: assert property (
    PREADY |=> !PREADY)
    else $error("PREADY held too long");
endmodule
bind dot_product_subtract_unit dpsub_assertions #(.ADDR_W(ADDR_W))
  dpsub_assertions_inst (.SYS_CLK, .SYS_RST, .INSTR_VALID, .INSTR_WORD,
  .LEFT_OPERAND_GPR, .RIGHT_OPERAND_GPR, .OP_DONE, .EXC_RESERVED,
  .EXC_SP_DISABLED, .OVERFLOW_FLAGS, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .PRDATA, .PREADY, .PSLVERR, .IRQ);

// ===== sim/core_issue_model.sv
/* Core-side model: decoder and register file issuing instructions.
   Assumes the bench calls issue and idle from one process. */
`timescale 1ns/100ps
module core_issue_model (
  input wire logic clk,
  output logic valid,
  output logic [31:0] word,
  output logic [31:0] left,
  output logic [31:0] right
);
  initial begin
    valid = 1'b0;
    word = 32'h0;
    left = 32'h0;
    right = 32'h0;
  end
  task automatic issue(input logic [31:0] w, l, r);
    @(posedge clk);
    valid <= 1'b1;
    word <= w;
    left <= l;
    right <= r;
  endtask
  // Released buses scramble so a stale operand is never trusted
  task automatic idle();
    @(posedge clk);
    valid <= 1'b0;
    word <= ~word;
    left <= ~left;
    right <= ~right;
  endtask
endmodule

// ===== sim/dot_product_subtract_unit_tb.sv
/* Self-checking bench for the dot-product subtract unit.
   Assumes the core issue model and the bound port checker. */
`timescale 1ns/100ps
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("Error at %0t: got %h want %h", $time, g, e); \
  end \
end
module dot_product_subtract_unit_tb;
  logic clk, rst, psel, penable, pwrite, err, valid, done, exr, exd;
  logic pready, pslverr, irq;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, word, left, right;
  logic [3:0] flags, xflags;
  logic [63:0] xacc [4];
  int num_errors = 0, tests_run = 0, cyc = 0;
  int n_done = 0, n_exr = 0, n_exd = 0;
  logic [7:0] tfn [6] = '{8'h9a, 8'h9a, 8'hca, 8'hca, 8'h92, 8'hca};
  logic [1:0] tsel [6] = '{2'h1, 2'h1, 2'h2, 2'h0, 2'h3, 2'h0};
  logic [31:0] ta [6] = '{32'h8000_8000, 32'h0003_fffe, 32'h7fff_7fff,
    32'h8001_8001, 32'hffff_1234, 32'h0001_0000};
  logic [31:0] tr [6] = '{32'h8000_8000, 32'h0002_0005, 32'h7fff_7fff,
    32'h7fff_7fff, 32'hffff_5678, 32'h0000_0001};
  dot_product_subtract_unit dot_product_subtract_unit_inst (.SYS_CLK(clk),
    .SYS_RST(rst), .INSTR_VALID(valid), .INSTR_WORD(word),
    .LEFT_OPERAND_GPR(left), .RIGHT_OPERAND_GPR(right), .OP_DONE(done),
    .EXC_RESERVED(exr), .EXC_SP_DISABLED(exd), .OVERFLOW_FLAGS(flags),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .IRQ(irq));
  core_issue_model core_issue_model_inst (.clk(clk), .valid(valid),
    .word(word), .left(left), .right(right));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic summarize();
    $display("Mismatches %0d of %0d checks", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    n_done += (done === 1'b1);
    n_exr += (exr === 1'b1);
    n_exd += (exd === 1'b1);
    if (cyc > 3000) begin
      num_errors++;
      summarize();
    end
  end
  function automatic logic [64:0] model(input logic [7:0] fn,
      input logic [63:0] acc, input logic [31:0] a, b);
    logic s;
    logic signed [31:0] m;
    logic [31:0] p [2];
    logic [63:0] d;
    s = 1'b0;
    for (int i = 0; i < 2; i++) begin
      m = $signed(a[16*i+:16]) * $signed(b[16-16*i+:16]);
      p[i] = m << 1;
      if (a[16*i+:16] == 16'h8000 && b[16-16*i+:16] == 16'h8000) begin
        p[i] = 32'h7fff_ffff;
        s = 1'b1;
      end
    end
    d = acc - ({{32{p[0][31]}}, p[0]} + {{32{p[1][31]}}, p[1]});
    if (fn == 8'h92) begin
      d = acc - ({56'h0, a[31:24]} * b[31:24] + {56'h0, a[23:16]} * b[23:16]);
      s = 1'b0;
    end
    if (fn == 8'hca && d[63:31] != {33{d[63]}}) begin
      d = d[63] ? 64'hffff_ffff_8000_0000 : 64'h0000_0000_7fff_ffff;
      s = 1'b1;
    end
    return {s, d};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask
  task automatic op(input logic [7:0] fn, input logic [1:0] s,
      input logic [31:0] a, b);
    logic [64:0] r;
    r = model(fn, xacc[s], a, b);
    xacc[s] = r[63:0];
    xflags[s] = xflags[s] | r[64];
    core_issue_model_inst.issue({6'h00, 10'h0, s, fn, 6'h3c}, a, b);
  endtask
  task automatic chk_accs();
    for (int i = 0; i < 4; i++) begin
      rchk(8'h10 + 8'(8 * i), xacc[i][31:0]);
      rchk(8'h14 + 8'(8 * i), xacc[i][63:32]);
    end
  endtask
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    xflags = 4'h0;
    xacc = '{default: 64'h0};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rchk(8'h00, 32'h1);
    rchk(8'h04, 32'h0);
    apb(1'b0, 8'h30, 32'h0);
    `CHK(err, 1'b1)
    apb(1'b1, 8'h28, 32'h10);
    apb(1'b1, 8'h2c, 32'h1);
    xacc[3] = 64'h1_0000_0010;
    // Issued back to back: each op must see the previous result
    for (int k = 0; k < 6; k++) op(tfn[k], tsel[k], ta[k], tr[k]);
    core_issue_model_inst.idle();
    repeat (2) @(negedge clk);
    `CHK(flags, xflags)
    `CHK(n_done, 6)
    chk_accs();
    rchk(8'h04, {12'h0, xflags, 16'h0});
    core_issue_model_inst.issue({6'h00, 10'h0, 2'h0, 8'h01, 6'h3c}, 32'h0,
      32'h0);
    core_issue_model_inst.idle();
    repeat (2) @(negedge clk);
    `CHK(n_exr, 1)
    apb(1'b1, 8'h00, 32'h0);
    core_issue_model_inst.issue({16'h0, 2'h3, 8'h9a, 6'h3c}, ta[0], tr[0]);
    core_issue_model_inst.idle();
    repeat (2) @(negedge clk);
    `CHK(n_exd, 1)
    `CHK(flags, xflags)
    apb(1'b1, 8'h00, 32'h1);
    chk_accs();
    `CHK(n_done, 6)
    rchk(8'h08, 32'h3);
    `CHK(irq, 1'b0)
    apb(1'b1, 8'h0c, 32'h1);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b1)
    apb(1'b1, 8'h08, 32'h3);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b0)
    summarize();
  end
endmodule
